//--- psseq_pkg.sv
// Package of the power slot sequencer: register map, reset values, timing.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.

package psseq_pkg;

  // Sizes
  localparam int unsigned NUM_CONV  = 4;
  localparam int unsigned NUM_LDO   = 10;
  localparam int unsigned NUM_RES   = 16;
  localparam int unsigned NUM_PIN   = 4;
  localparam int unsigned RES_LDO0  = 4;
  localparam int unsigned RES_CLK   = 14;
  localparam int unsigned RES_POR   = 15;
  localparam logic [3:0]  LAST_SLOT = 4'hf;
  localparam logic [1:0]  LAST_SSLOT = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_ENABLE   = 8'h08;
  localparam logic [7:0] OFS_STAY_ON  = 8'h0c;
  localparam logic [7:0] OFS_TURN_OFF = 8'h10;
  localparam logic [7:0] OFS_LOW_PWR  = 8'h14;
  localparam logic [7:0] OFS_SLOT_LO  = 8'h18;
  localparam logic [7:0] OFS_SLOT_HI  = 8'h1c;
  localparam logic [7:0] OFS_PIN_LO   = 8'h20;
  localparam logic [7:0] OFS_PIN_HI   = 8'h24;
  localparam logic [7:0] OFS_SLP_SLOT = 8'h28;
  localparam logic [7:0] OFS_OUTS     = 8'h2c;

  // Field positions
  localparam int unsigned CTRL_DLY_LSB = 0;
  localparam int unsigned CTRL_BRK_LSB = 2;

  // Reset values (factory sequence)
  localparam logic [5:0]  CTRL_RST     = 6'h00;
  localparam logic [13:0] ENABLE_RST   = 14'h3fff;
  localparam logic [9:0]  STAY_ON_RST  = 10'h000;
  localparam logic [9:0]  TURN_OFF_RST = 10'h000;
  localparam logic [9:0]  LOW_PWR_RST  = 10'h000;
  localparam logic [31:0] SLOT_LO_RST  = 32'h5432_4321;
  localparam logic [31:0] SLOT_HI_RST  = 32'hf700_0076;
  localparam logic [31:0] PIN_LO_RST   = 32'h0000_0000;
  localparam logic [31:0] PIN_HI_RST   = 32'h0000_0000;
  localparam logic [31:0] SLP_SLOT_RST = 32'h0000_0000;

  // LDO modes
  localparam logic [1:0] LM_OFF    = 2'h0;
  localparam logic [1:0] LM_NORMAL = 2'h1;
  localparam logic [1:0] LM_LOWPWR = 2'h2;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T30US_NS  = 30000;
  localparam int unsigned T200US_NS = 200000;
  localparam int unsigned T500US_NS = 500000;
  localparam int unsigned T2MS_NS   = 2000000;
  localparam int unsigned T120US_NS = 120000;
  localparam int unsigned T30US_CYC  =
    (T30US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T200US_CYC =
    (T200US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T500US_CYC =
    (T500US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T2MS_CYC   =
    (T2MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T120US_CYC =
    (T120US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- psseq_ldo_mode.sv
// Mode resolver for one linear regulator: off, normal or low-power.
// Assumes synchronised inputs; output is combinational, the top registers it.
`timescale 1ns/1ps

module psseq_ldo_mode (
  input  wire logic       enable_i,   // Enable bit and power gate
  input  wire logic       mapped_i,   // Regulator is mapped to a pin
  input  wire logic       pin_hi_i,   // OR of mapped pins
  input  wire logic       stay_on_i,  // Stay-on bit
  input  wire logic       turn_off_i, // Turn-off bit
  input  wire logic       low_pwr_i,  // Low-power bit
  input  wire logic       strap_hi_i, // Strap tied to the always-on supply
  input  wire logic       sleep_i,    // Regulator sees the SLEEP state
  output logic      [1:0] mode_o      // Resolved mode
);
  import psseq_pkg::*;

  logic [1:0] mapped_mode;
  logic [1:0] unmapped_mode;
  logic [1:0] sleep_mode;
  logic       plain_case;

  // Pin-mapped regulator: pin high or stay-on keeps it in normal mode
  assign mapped_mode = (pin_hi_i | stay_on_i) ? LM_NORMAL :
                       turn_off_i ? LM_OFF : LM_LOWPWR;

  // Strap ground or not asleep: only the low-power bit counts
  assign plain_case = ~strap_hi_i | ~sleep_i;
  assign sleep_mode = stay_on_i  ? (low_pwr_i ? LM_LOWPWR : LM_NORMAL)
                    : turn_off_i ? LM_OFF : LM_LOWPWR;
  assign unmapped_mode = plain_case ?
                         (low_pwr_i ? LM_LOWPWR : LM_NORMAL)
                         : sleep_mode;

  // A cleared enable wins over every other combination; one mode results
  assign mode_o = !enable_i ? LM_OFF :
                  mapped_i  ? mapped_mode : unmapped_mode;

endmodule

//--- psseq_top.sv
// Power slot sequencer: slot walks for power-up, power-down and sleep,
// resource gating and LDO mode resolution, with an APB register file.
// Assumes requests, enable pins, monitor and strap come from pins.
`timescale 1ns/1ps

module psseq_top #(
  parameter int unsigned SLOT_500US_CYC = psseq_pkg::T500US_CYC,
  parameter int unsigned SLOT_2MS_CYC   = psseq_pkg::T2MS_CYC
) (
  input  wire logic        sys_clk_i,      // 10 MHz system clock
  input  wire logic        reset_n_i,      // Asynchronous reset, low
  input  wire logic        psel_i,         // APB select
  input  wire logic        penable_i,      // APB enable
  input  wire logic        pwrite_i,       // APB write
  input  wire logic [7:0]  paddr_i,        // APB byte address
  input  wire logic [31:0] pwdata_i,       // APB write data
  output logic      [31:0] prdata_o,       // APB read data
  output logic             pready_o,       // APB ready
  output logic             pslverr_o,      // APB error
  input  wire logic        pwr_on_req_i,   // Power-on condition, pin
  input  wire logic        sleep_req_i,    // Sleep condition, pin
  input  wire logic [3:0]  en_pin_i,       // External enable pins
  input  wire logic        vmon_ok_i,      // Monitors above threshold
  input  wire logic        config_strap_i, // High: tied to always-on supply
  output logic      [3:0]  conv_en_o,      // Converter enables
  output logic      [19:0] ldo_mode_o,     // Two mode bits per LDO
  output logic             clk32_en_o,     // 32 kHz clock output enable
  output logic             por_n_o         // Power-on reset output, low
);
  import psseq_pkg::*;

  typedef enum logic [2:0] {
    ST_OFF, ST_UP, ST_HOLD, ST_ACTIVE, ST_SLP_IN, ST_SLEEP, ST_SLP_OUT,
    ST_DOWN
  } psseq_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic       pwr_on;
  logic       sleep_req;
  logic [3:0] en_pin;
  logic       vmon_ok;
  logic       strap_hi;

  // Two stages; only the second stage is read by logic
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= {pwr_on_req_i, sleep_req_i, en_pin_i, vmon_ok_i,
                  config_strap_i};
      sync2_r <= sync1_r;
    end
  end

  assign pwr_on    = sync2_r[7];
  assign sleep_req = sync2_r[6];
  assign en_pin    = sync2_r[5:2];
  assign vmon_ok   = sync2_r[1];
  assign strap_hi  = sync2_r[0];

  //////////////////////////////////////////////////////////////////////////
  // Registers

  logic [5:0]  ctrl_r;
  logic [13:0] enable_r;
  logic [9:0]  stay_on_r;
  logic [9:0]  turn_off_r;
  logic [9:0]  low_pwr_r;
  logic [31:0] slot_lo_r;
  logic [31:0] slot_hi_r;
  logic [31:0] pin_lo_r;
  logic [31:0] pin_hi_r;
  logic [31:0] slp_slot_r;
  logic [31:0] prdata_r;

  logic        setup;
  logic        wr_go;
  logic        hit;
  logic [31:0] rd_mux;
  logic [1:0]  dly_sel;
  logic [3:0]  brk_slot;

  // Setup phase latches read data; access phase commits writes
  assign setup    = psel_i & ~penable_i;
  assign wr_go    = psel_i & penable_i & pwrite_i & hit;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;
  assign prdata_o = prdata_r;
  assign dly_sel  = ctrl_r[CTRL_DLY_LSB +: 2];
  assign brk_slot = ctrl_r[CTRL_BRK_LSB +: 4];

  // Address decode; unmapped offsets answer with an error
  assign hit = (paddr_i[1:0] == 2'h0) &&
               (paddr_i[7:2] <= OFS_OUTS[7:2]);

  psseq_state_t st_r;
  logic [3:0]   slot_r;
  logic [15:0]  seq_on_r;
  logic [15:0]  slp_r;
  logic [15:0]  res_on;

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      OFS_CTRL:     rd_mux = {26'h0, ctrl_r};
      OFS_STATUS:   rd_mux = {22'h0, strap_hi, vmon_ok, slot_r, 1'b0,
                              st_r};
      OFS_ENABLE:   rd_mux = {18'h0, enable_r};
      OFS_STAY_ON:  rd_mux = {22'h0, stay_on_r};
      OFS_TURN_OFF: rd_mux = {22'h0, turn_off_r};
      OFS_LOW_PWR:  rd_mux = {22'h0, low_pwr_r};
      OFS_SLOT_LO:  rd_mux = slot_lo_r;
      OFS_SLOT_HI:  rd_mux = slot_hi_r;
      OFS_PIN_LO:   rd_mux = pin_lo_r;
      OFS_PIN_HI:   rd_mux = pin_hi_r;
      OFS_SLP_SLOT: rd_mux = slp_slot_r;
      OFS_OUTS:     rd_mux = {16'h0, res_on};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Write port and read data capture
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r     <= CTRL_RST;
      enable_r   <= ENABLE_RST;
      stay_on_r  <= STAY_ON_RST;
      turn_off_r <= TURN_OFF_RST;
      low_pwr_r  <= LOW_PWR_RST;
      slot_lo_r  <= SLOT_LO_RST;
      slot_hi_r  <= SLOT_HI_RST;
      pin_lo_r   <= PIN_LO_RST;
      pin_hi_r   <= PIN_HI_RST;
      slp_slot_r <= SLP_SLOT_RST;
      prdata_r   <= 32'h0000_0000;
    end else begin
      if (setup) begin
        prdata_r <= rd_mux;
      end
      if (wr_go) begin
        case (paddr_i)
          OFS_CTRL:     ctrl_r     <= pwdata_i[5:0];
          OFS_ENABLE:   enable_r   <= pwdata_i[13:0];
          OFS_STAY_ON:  stay_on_r  <= pwdata_i[9:0];
          OFS_TURN_OFF: turn_off_r <= pwdata_i[9:0];
          OFS_LOW_PWR:  low_pwr_r  <= pwdata_i[9:0];
          OFS_SLOT_LO:  slot_lo_r  <= pwdata_i;
          OFS_SLOT_HI:  slot_hi_r  <= pwdata_i;
          OFS_PIN_LO:   pin_lo_r   <= pwdata_i;
          OFS_PIN_HI:   pin_hi_r   <= pwdata_i;
          OFS_SLP_SLOT: slp_slot_r <= pwdata_i;
          default:      ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slot decoding

  logic [63:0] slot_map;
  logic [63:0] pin_map;

  assign slot_map = {slot_hi_r, slot_lo_r};
  assign pin_map  = {pin_hi_r, pin_lo_r};

  // Resources whose four-bit slot field equals the slot; any count fits
  function automatic logic [15:0] slot_mask(input logic [63:0] map,
                                            input logic [3:0]  s);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (map[4*i +: 4] == s);
    end
    return m;
  endfunction

  // Resources whose two-bit sleep slot field equals the slot
  function automatic logic [15:0] sslot_mask(input logic [31:0] map,
                                             input logic [1:0]  s);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (map[2*i +: 2] == s);
    end
    return m;
  endfunction

  // Cycle count of one slot delay, shared by all fifteen slots
  function automatic logic [14:0] slot_cycles(input logic [1:0] sel);
    logic [14:0] c;
    case (sel)
      2'h0:    c = 15'(T30US_CYC);
      2'h1:    c = 15'(T200US_CYC);
      2'h2:    c = 15'(SLOT_500US_CYC);
      default: c = 15'(SLOT_2MS_CYC);
    endcase
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  psseq_state_t st_nxt;
  logic [3:0]   slot_nxt;
  logic [14:0]  tmr_r;
  logic [14:0]  tmr_nxt;
  logic [15:0]  seq_on_nxt;
  logic [15:0]  slp_nxt;
  logic [15:0]  cur_mask;
  logic [15:0]  cur_smask;
  logic [14:0]  dly;
  logic         tmr_done;
  logic         brk_hit;
  logic         up_go;
  logic         sleep_ok;

  assign dly       = slot_cycles(dly_sel);
  assign tmr_done  = (tmr_r == 15'h0000);
  assign cur_mask  = slot_mask(slot_map, slot_r);
  assign cur_smask = sslot_mask(slp_slot_r, slot_r[1:0]);
  // Break slot zero means no break point
  assign brk_hit   = (brk_slot != 4'h0) && (slot_r == brk_slot);
  assign up_go     = (st_r == ST_UP && tmr_done && !(brk_hit && !vmon_ok))
                   || (st_r == ST_HOLD && vmon_ok);
  // Sleep is refused while the strap sits on the always-on supply
  assign sleep_ok  = sleep_req & ~strap_hi;

  // Next state; the timer reloads before every slot, even an empty one
  always_comb begin
    st_nxt     = st_r;
    slot_nxt   = slot_r;
    tmr_nxt    = tmr_done ? tmr_r : tmr_r - 15'h0001;
    seq_on_nxt = seq_on_r;
    slp_nxt    = slp_r;
    case (st_r)
      ST_OFF: begin
        if (pwr_on) begin
          st_nxt   = ST_UP;
          slot_nxt = 4'h1;
          tmr_nxt  = dly;
        end
      end
      ST_UP, ST_HOLD: begin
        if (!pwr_on) begin
          st_nxt  = ST_DOWN;
          tmr_nxt = dly;
        end else if (st_r == ST_UP && tmr_done && brk_hit && !vmon_ok) begin
          st_nxt = ST_HOLD;
        end else if (up_go) begin
          seq_on_nxt = seq_on_r | cur_mask;
          if (slot_r == LAST_SLOT) begin
            st_nxt = ST_ACTIVE;
          end else begin
            st_nxt   = ST_UP;
            slot_nxt = slot_r + 4'h1;
            tmr_nxt  = dly;
          end
        end
      end
      ST_ACTIVE: begin
        if (!pwr_on) begin
          st_nxt   = ST_DOWN;
          slot_nxt = LAST_SLOT;
          tmr_nxt  = dly;
        end else if (sleep_ok) begin
          st_nxt   = ST_SLP_IN;
          slot_nxt = 4'h1;
          tmr_nxt  = 15'(T120US_CYC);
        end
      end
      ST_SLP_IN: begin
        if (tmr_done) begin
          slp_nxt = slp_r | cur_smask;
          if (slot_r[1:0] == LAST_SSLOT) begin
            st_nxt = ST_SLEEP;
          end else begin
            slot_nxt = slot_r + 4'h1;
            tmr_nxt  = 15'(T120US_CYC);
          end
        end
      end
      ST_SLEEP: begin
        if (!sleep_ok || !pwr_on) begin
          st_nxt   = ST_SLP_OUT;
          slot_nxt = {2'h0, LAST_SSLOT};
          tmr_nxt  = 15'(T120US_CYC);
        end
      end
      ST_SLP_OUT: begin
        if (tmr_done) begin
          slp_nxt = slp_r & ~cur_smask;
          if (slot_r == 4'h1) begin
            st_nxt = ST_ACTIVE;
          end else begin
            slot_nxt = slot_r - 4'h1;
            tmr_nxt  = 15'(T120US_CYC);
          end
        end
      end
      ST_DOWN: begin
        if (tmr_done) begin
          seq_on_nxt = seq_on_r & ~cur_mask;
          if (slot_r == 4'h1) begin
            st_nxt = ST_OFF;
          end else begin
            slot_nxt = slot_r - 4'h1;
            tmr_nxt  = dly;
          end
        end
      end
      default: begin
        st_nxt = ST_OFF;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r     <= ST_OFF;
      slot_r   <= 4'h0;
      tmr_r    <= 15'h0000;
      seq_on_r <= 16'h0000;
      slp_r    <= 16'h0000;
    end else begin
      st_r     <= st_nxt;
      slot_r   <= slot_nxt;
      tmr_r    <= tmr_nxt;
      seq_on_r <= seq_on_nxt;
      slp_r    <= slp_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Resource gating

  logic        act_slp;
  logic        dev_sleep;
  logic [15:0] seqd;
  logic [15:0] mapped;
  logic [15:0] pin_hi;
  logic [15:0] gate;
  logic [15:0] res_nxt;
  logic [19:0] ldo_mode;
  logic [3:0]  conv_en_r;
  logic [19:0] ldo_mode_r;
  logic [1:0]  misc_r;

  // Pins and unsequenced resources only act in ST_ACTIVE, ST_SLP_IN, ST_SLEEP or ST_SLP_OUT
  assign act_slp   = (st_r == ST_ACTIVE) || (st_r == ST_SLP_IN) ||
                     (st_r == ST_SLEEP)  || (st_r == ST_SLP_OUT);
  assign dev_sleep = (st_r == ST_SLEEP);

  // A resource with slot zero stays outside the automatic walk.
  // Mapping a sequenced resource to a pin is left to configuration; the
  // sequence then wins and the pin is ignored.
  for (genvar i = 0; i < 16; i++) begin : g_res
    assign seqd[i]   = (slot_map[4*i +: 4] != 4'h0);
    assign mapped[i] = |pin_map[4*i +: 4];
    assign pin_hi[i] = |(pin_map[4*i +: 4] & en_pin);
    assign gate[i]   = seqd[i] ? seq_on_r[i] & ~slp_r[i]
                     : act_slp & (~mapped[i] | pin_hi[i]);
  end

  // Converters also need their enable bit; clock and reset do not
  assign res_nxt = {gate[15:14], 10'h000, gate[3:0] & enable_r[3:0]};

  // One resolver per linear regulator
  for (genvar j = 0; j < NUM_LDO; j++) begin : g_ldo
    psseq_ldo_mode u_mode (
      .enable_i   (enable_r[4+j] &
                   (seqd[4+j] ? seq_on_r[4+j] : act_slp)),
      .mapped_i   (mapped[4+j] & ~seqd[4+j]),
      .pin_hi_i   (pin_hi[4+j]),
      .stay_on_i  (stay_on_r[j]),
      .turn_off_i (turn_off_r[j]),
      .low_pwr_i  (low_pwr_r[j]),
      .strap_hi_i (strap_hi),
      .sleep_i    (slp_r[4+j] | dev_sleep),
      .mode_o     (ldo_mode[2*j +: 2])
    );
  end

  // Outputs come from flip-flops so pins never glitch on decode
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_en_r  <= 4'h0;
      ldo_mode_r <= 20'h00000;
      misc_r     <= 2'h0;
    end else begin
      conv_en_r  <= res_nxt[3:0];
      ldo_mode_r <= ldo_mode;
      misc_r     <= res_nxt[15:14];
    end
  end

  // Status view of every resource, LDOs on when not off
  for (genvar k = 0; k < NUM_LDO; k++) begin : g_on
    assign res_on[4+k] = (ldo_mode_r[2*k +: 2] != LM_OFF);
  end
  assign res_on[3:0]   = conv_en_r;
  assign res_on[15:14] = misc_r;

  assign conv_en_o  = conv_en_r;
  assign ldo_mode_o = ldo_mode_r;
  assign clk32_en_o = misc_r[0];
  // Reset output stays asserted until its slot releases it
  assign por_n_o    = misc_r[1];

endmodule

//--- psseq_rail_model.sv
// Rail model: monitors go good a while after rails 0 and 1 are on.
// Assumes converter enables from the sequencer; hold_i keeps the monitors low.
`timescale 1ns/1ps
module psseq_rail_model #(
  parameter int unsigned RAMP = 20
) (
  input  wire logic       sys_clk_i, // Clock
  input  wire logic       reset_n_i, // Reset, low
  input  wire logic [3:0] conv_en_i, // Converter enables
  input  wire logic       hold_i,    // Keep monitors low
  output logic            vmon_ok_o  // Monitors good
);
  logic [7:0] ramp_r;
  // Ramp restarts when rail 0 or 1 drops, so a break is not passed early
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) ramp_r <= 8'h00;
    else if (hold_i || !(&conv_en_i[1:0])) ramp_r <= 8'h00;
    else if (ramp_r != RAMP[7:0]) ramp_r <= ramp_r + 8'h01;
  end
  assign vmon_ok_o = (ramp_r == RAMP[7:0]);
endmodule

//--- psseq_checker.sv
// Port checker: slot order and spacing, mode codes.
// Assumes the factory slot map; sleep slots leave rails 0..2 and reset.
`timescale 1ns/1ps
module psseq_checker #(
  parameter int unsigned SLOT_500US_CYC = 50,
  parameter int unsigned SLOT_2MS_CYC   = 200
) (
  input wire logic        sys_clk_i,  // Clock
  input wire logic        reset_n_i,  // Reset, low
  input wire logic [3:0]  conv_en_o,  // Converters
  input wire logic [19:0] ldo_mode_o, // LDO modes
  input wire logic        clk32_en_o, // Clock out
  input wire logic        por_n_o     // Reset out
);
  logic [15:0] age_r;
  logic        bad_mode;
  // Age of rail 0; a short gap to slot 2 means a lost delay
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) age_r <= 16'h0000;
    else if (!conv_en_o[0]) age_r <= 16'h0000;
    else if (age_r != 16'hffff) age_r <= age_r + 16'h0001;
  end
  // Code three is no mode at all
  always_comb begin
    bad_mode = 1'b0;
    for (int j = 0; j < 10; j++) bad_mode |= ldo_mode_o[2*j+:2] == 2'h3;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////
  property p_up;
    $rose(conv_en_o[2]) |-> conv_en_o[1:0] == 2'h3;
  endproperty
  a_up: assert property (p_up) else $error("slot order");
  property p_last;
    $rose(por_n_o) |-> {clk32_en_o, conv_en_o} == 5'h1f;
  endproperty
  a_last: assert property (p_last) else $error("reset early");
  property p_gap;
    $rose(conv_en_o[1]) |-> age_r >= SLOT_500US_CYC || age_r >= 16'h012c;
  endproperty
  a_gap: assert property (p_gap) else $error("slot gap");
  property p_off1;
    $fell(por_n_o) |-> conv_en_o == 4'hf;
  endproperty
  a_off1: assert property (p_off1) else $error("down start");
  property p_off2;
    $fell(conv_en_o[1]) |-> conv_en_o[0] && !conv_en_o[2];
  endproperty
  a_off2: assert property (p_off2) else $error("down order");
  property p_off3;
    $fell(conv_en_o[0]) |-> !por_n_o && !clk32_en_o;
  endproperty
  a_off3: assert property (p_off3) else $error("down end");
  property p_mode;
    !bad_mode;
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_unseq;
    $rose(conv_en_o[0]) |-> ldo_mode_o[19:12] == 8'h00;
  endproperty
  a_unseq: assert property (p_unseq) else $error("unseq on");
  c_up: cover property ($rose(por_n_o));
  c_down: cover property ($fell(conv_en_o[0]));
  c_low: cover property (ldo_mode_o[15:14] == 2'h2);
endmodule
bind psseq_top psseq_checker #(.SLOT_500US_CYC(SLOT_500US_CYC),
  .SLOT_2MS_CYC(SLOT_2MS_CYC)) u_chk (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .conv_en_o(conv_en_o), .ldo_mode_o(ldo_mode_o),
  .clk32_en_o(clk32_en_o), .por_n_o(por_n_o));

//--- power_slot_sequencer_ldo_mode_bench.sv
// Bench of the slot sequencer: bus, power walks, LDO modes.
// Assumes the factory slot map; delay codes 2 and 3 shortened to 50, 200.
`timescale 1ns/1ps
module power_slot_sequencer_ldo_mode_bench;
  import psseq_pkg::*;
  logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0;
  logic        penable = 1'b0, pwrite = 1'b0, pwr_on = 1'b0, hold = 1'b1;
  logic        sleep = 1'b0, strap = 1'b0;
  logic [5:0]  outs;
  logic        pready, pslverr, vmon_ok, clk32_en, por_n, err;
  logic [7:0]  paddr = 8'h00;
  logic [3:0]  en_pin = 4'h0, conv_en;
  logic [19:0] ldo_mode;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  int          fail_count = 0, checked = 0, n;
  always #50 sys_clk = ~sys_clk;
  psseq_top #(.SLOT_500US_CYC(50), .SLOT_2MS_CYC(200)) uut (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pwr_on_req_i(pwr_on), .sleep_req_i(sleep),
    .en_pin_i(en_pin), .vmon_ok_i(vmon_ok), .config_strap_i(strap),
    .conv_en_o(conv_en), .ldo_mode_o(ldo_mode), .clk32_en_o(clk32_en),
    .por_n_o(por_n));
  psseq_rail_model rails (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .conv_en_i(conv_en), .hold_i(hold), .vmon_ok_o(vmon_ok));
  assign outs = {clk32_en, por_n, conv_en};
  task chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) fail_count++;
    err = pslverr;
    rdata = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Bits 0..3 converters, 4 reset out, 5 clock out; looked at mid-cycle
  task wait_bit(input int idx, input logic lvl);
    n = 0;
    while (outs[idx] !== lvl && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (outs[idx] !== lvl) fail_count++;
  endtask
  // Pins take two sync stages and the mode one register
  task chk_ldo(input int j, input logic [1:0] exp);
    repeat (6) @(posedge sys_clk);
    chk("ldo mode", {30'h0, ldo_mode[2*j+:2]}, {30'h0, exp});
  endtask
  task t_up;
    apb(1'b0, OFS_ENABLE, 32'h0);
    chk("enable reset", rdata, {18'h0, ENABLE_RST});
    apb(1'b1, 8'h30, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0000_000e);  // Break at slot 3
    pwr_on <= 1'b1;
    wait_bit(0, 1'b1);
    wait_bit(1, 1'b1);
    chk("up gap", n, 32'h33);
    repeat (400) @(posedge sys_clk);
    chk("break", {31'h0, conv_en[2]}, 32'h0);
    hold <= 1'b0;
    wait_bit(4, 1'b1);
    chk("all on", {27'h0, clk32_en, conv_en}, 32'h1f);
  endtask
  task t_modes;
    apb(1'b1, OFS_TURN_OFF, 32'h0c0);
    apb(1'b1, OFS_LOW_PWR, 32'h040);
    chk_ldo(6, LM_LOWPWR);
    apb(1'b1, OFS_LOW_PWR, 32'h000);
    chk_ldo(6, LM_NORMAL);
    apb(1'b1, OFS_ENABLE, 32'h3bff);
    chk_ldo(6, LM_OFF);
    apb(1'b1, OFS_PIN_HI, 32'h3000);  // Unsequenced LDO only
    chk_ldo(7, LM_OFF);
    apb(1'b1, OFS_STAY_ON, 32'h080);
    chk_ldo(7, LM_NORMAL);
    apb(1'b1, OFS_STAY_ON, 32'h000);
    apb(1'b1, OFS_TURN_OFF, 32'h000);
    chk_ldo(7, LM_LOWPWR);
    en_pin <= 4'h2;
    chk_ldo(7, LM_NORMAL);
    apb(1'b1, OFS_ENABLE, 32'h37ff);
    chk_ldo(7, LM_OFF);
    en_pin <= 4'h0;
  endtask
  // Sleep walk: clock out at slot 1, rail 3 at slot 2, LDO6 at slot 3
  task t_sleep;
    apb(1'b1, OFS_SLP_SLOT, 32'h1030_0080);
    apb(1'b1, OFS_TURN_OFF, 32'h040);
    sleep <= 1'b1;
    wait_bit(5, 1'b0);
    wait_bit(3, 1'b0);
    chk("sleep gap", n, T120US_CYC + 1);
    repeat (1300) @(posedge sys_clk);
    chk_ldo(6, LM_NORMAL);
    // Strap high while asleep also ends the sleep; LDO6 keeps its view
    strap <= 1'b1;
    chk_ldo(6, LM_OFF);
    wait_bit(3, 1'b1);
    wait_bit(5, 1'b1);
    chk("wake gap", n, T120US_CYC + 1);
    repeat (20) @(posedge sys_clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("no sleep", {29'h0, rdata[2:0]}, 32'h3);
    chk_ldo(6, LM_NORMAL);
    sleep <= 1'b0;
    strap <= 1'b0;
  endtask
  task t_down;
    apb(1'b1, OFS_CTRL, 32'h0000_000f);  // 2 ms code, break kept
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rdata, 32'hf);
    pwr_on <= 1'b0;
    wait_bit(4, 1'b0);
    chk("down first", {28'h0, conv_en}, 32'hf);
    wait_bit(1, 1'b0);
    chk("down last", {31'h0, conv_en[0]}, 32'h1);
    wait_bit(0, 1'b0);
    chk("down gap", n, 32'hc9);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_up;
    t_modes;
    t_sleep;
    t_down;
    test_done;
  end
  // The walks take some 11600 cycles; a hang ends well beyond that
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    test_done;
  end
endmodule
